// [design/bsvc_regs.vh]
// constants for the boot strap vector capture block
//
// Contract
// - vector is sampled from the memory data bus only during cold reset
// - captured settings apply from cold reset end and stay fixed afterwards
// - bits 2:0 pick clock multiplier; 0 is times two, others reserved
// - bit 3 picks byte order; 0 little endian, 1 big endian
// - reserved bit 4 is kept in the status vector field for software
// - bits 6:5 pick boot width 8, 16 or 32; code 3 reserved
// - bit 7 zero means warm reset line driven at least 4096 cycles
// - bit 8 set leaves the watchdog disabled after cold reset
// - bits 11:9 pick pci mode; codes 6 and 7 reserved
// - pci enable resets to one for modes 1 and 2, else zero
// - reserved bits 15:12 are kept in the status vector field
// - cold reset initialises state, loads vector, and relocks the pll
// - device drives warm reset line low; outsiders may force warm reset
`ifndef BSVC_REGS_VH
`define BSVC_REGS_VH

`define BSVC_ADDR_W 8
`define BSVC_OFF_VECTOR 8'h00
`define BSVC_OFF_PCI_CTRL 8'h04
`define BSVC_OFF_CONFIG 8'h08
`define BSVC_OFF_WARM_CTRL 8'h0c

`define BSVC_VEC_W 16
`define BSVC_F_MULT_LO 0
`define BSVC_F_MULT_HI 2
`define BSVC_F_ENDIAN 3
`define BSVC_F_WIDTH_LO 5
`define BSVC_F_WIDTH_HI 6
`define BSVC_F_RST_MODE 7
`define BSVC_F_WDOG_DIS 8
`define BSVC_F_PCI_LO 9
`define BSVC_F_PCI_HI 11

`define BSVC_MULT_X2 3'h0
`define BSVC_WIDTH_RSVD 2'h3
`define BSVC_PCI_DISABLED 3'h0
`define BSVC_PCI_SAT_NOT_READY 3'h1
`define BSVC_PCI_SAT_SUSPEND 3'h2
`define BSVC_PCI_HOST_RR 3'h5

`define BSVC_VEC_RESET 16'h0000
`define BSVC_PCI_EN_RESET 1'b0
`define BSVC_WARM_DRIVE_CYCLES 4096

`endif

// [design/bsvc_decode.v]
// splits the captured vector into registered settings
`timescale 1ns/1ps
`include "bsvc_regs.vh"

module bsvc_decode
(
    input wire core_clk,
    input wire reset_n,
    input wire load,
    input wire [`BSVC_VEC_W-1:0] vector,
    output reg [2:0] cpu_clk_mult,
    output reg big_endian,
    output reg [1:0] boot_width,
    output reg reset_mode,
    output reg watchdog_enable,
    output reg [2:0] pci_mode,
    output reg reserved_code
);

    // fields move only on load, so they stay fixed between cold resets
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cpu_clk_mult <= `BSVC_MULT_X2;
            big_endian <= 1'b0;
            boot_width <= 2'h0;
            reset_mode <= 1'b0;
            watchdog_enable <= 1'b1;
            pci_mode <= `BSVC_PCI_DISABLED;
            reserved_code <= 1'b0;
        end
        else if (load)
        begin
            cpu_clk_mult <= vector[`BSVC_F_MULT_HI:`BSVC_F_MULT_LO];
            big_endian <= vector[`BSVC_F_ENDIAN];
            boot_width <= vector[`BSVC_F_WIDTH_HI:`BSVC_F_WIDTH_LO];
            reset_mode <= vector[`BSVC_F_RST_MODE];
            watchdog_enable <= ~vector[`BSVC_F_WDOG_DIS];
            pci_mode <= vector[`BSVC_F_PCI_HI:`BSVC_F_PCI_LO];
            // flags a vector that breaks the strapping contract
            reserved_code <=
                (vector[`BSVC_F_MULT_HI:`BSVC_F_MULT_LO] != `BSVC_MULT_X2)
                | (vector[`BSVC_F_WIDTH_HI:`BSVC_F_WIDTH_LO]
                   == `BSVC_WIDTH_RSVD)
                | vector[`BSVC_F_RST_MODE]
                | (vector[`BSVC_F_PCI_HI:`BSVC_F_PCI_LO]
                   > `BSVC_PCI_HOST_RR);
        end
    end

endmodule // bsvc_decode

// [design/bsvc_warm_drive.v]
// drives the open-drain warm reset line low for a fixed count
`timescale 1ns/1ps
`include "bsvc_regs.vh"

module bsvc_warm_drive
#(
    parameter CYCLES = `BSVC_WARM_DRIVE_CYCLES
)
(
    input wire core_clk,
    input wire reset_n,
    input wire start,
    output reg line_out,
    output reg line_oe,
    output reg busy
);

    function integer bsvc_clog2;
        input integer value;
        integer v;
        begin
            v = value - 1;
            bsvc_clog2 = 1;
            while (v > 1)
            begin
                v = v >> 1;
                bsvc_clog2 = bsvc_clog2 + 1;
            end
        end
    endfunction

    localparam CW = bsvc_clog2(CYCLES) + 1;
    localparam integer LAST_I = CYCLES - 1;
    // cut on purpose: CW bits always hold the largest count value
    localparam [CW-1:0] LAST = LAST_I[CW-1:0];

    reg [CW-1:0] count;

    // a start while busy is ignored; the running stretch is not extended
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count <= {CW{1'b0}};
            line_out <= 1'b1;
            line_oe <= 1'b0;
            busy <= 1'b0;
        end
        else if (!busy && start)
        begin
            count <= {CW{1'b0}};
            line_out <= 1'b0;
            line_oe <= 1'b1;
            busy <= 1'b1;
        end
        else if (busy)
        begin
            if (count == LAST)
            begin
                line_out <= 1'b1;
                line_oe <= 1'b0;
                busy <= 1'b0;
            end
            else
            begin
                count <= count + {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule // bsvc_warm_drive

// [design/bsvc_top.v]
// boot strap vector capture with settings outputs and register port
`timescale 1ns/1ps
`include "bsvc_regs.vh"

module bsvc_top
#(
    parameter WARM_DRIVE_CYCLES = `BSVC_WARM_DRIVE_CYCLES
)
(
    input wire core_clk,
    input wire reset_n,
    input wire cold_reset_n,
    input wire [`BSVC_VEC_W-1:0] memory_data_bus,
    input wire warm_reset_line_n_in,
    output wire warm_reset_line_n_out,
    output wire warm_reset_line_n_oe,
    input wire [`BSVC_ADDR_W-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [31:0] reg_rdata,
    output wire [2:0] cpu_clk_mult,
    output wire big_endian,
    output wire [1:0] boot_width,
    output wire watchdog_enable,
    output wire [2:0] pci_mode,
    output reg pci_enable,
    output reg config_valid,
    output reg pll_relock,
    output reg cold_reset_active,
    output reg warm_reset_exception
);

    function pci_en_for_mode;
        input [2:0] mode;
        begin
            pci_en_for_mode = (mode == `BSVC_PCI_SAT_NOT_READY)
                || (mode == `BSVC_PCI_SAT_SUSPEND);
        end
    endfunction

    function addr_hit;
        input [`BSVC_ADDR_W-1:0] addr;
        input [`BSVC_ADDR_W-1:0] offset;
        begin
            addr_hit = (addr == offset);
        end
    endfunction

    reg cold_prev;
    reg [`BSVC_VEC_W-1:0] shadow;
    reg [`BSVC_VEC_W-1:0] vector;
    reg capture;
    reg soft_warm;
    reg ext_guard;
    reg [31:0] next_rdata;

    wire reset_mode;
    wire reserved_code;
    wire drive_busy;
    wire cold_release;
    wire ext_warm;
    wire warm_start;

    // cold reset input is taken as synchronous; release is its rising edge
    assign cold_release = !cold_prev && cold_reset_n;

    // our own drive reads back low, so only a low seen while idle and
    // past the one-cycle release guard counts as an outside request
    assign ext_warm = config_valid && !drive_busy && !ext_guard
        && !warm_reset_line_n_in;

    assign warm_start = capture || soft_warm || ext_warm;

    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            // idle level, so a cold reset already released is no edge
            cold_prev <= 1'b1;
            shadow <= `BSVC_VEC_RESET;
            vector <= `BSVC_VEC_RESET;
            capture <= 1'b0;
            config_valid <= 1'b0;
            pll_relock <= 1'b1;
            cold_reset_active <= 1'b1;
        end
        else
        begin
            cold_prev <= cold_reset_n;
            cold_reset_active <= !cold_reset_n;
            // the pll is held to relock for the whole cold reset
            pll_relock <= !cold_reset_n;
            capture <= cold_release;
            if (!cold_reset_n)
            begin
                // keeps the last level seen before release, so data that
                // only hold a few ns past the rising edge are still safe
                shadow <= memory_data_bus;
                config_valid <= 1'b0;
            end
            if (cold_release)
            begin
                vector <= shadow;
                config_valid <= 1'b1;
            end
        end
    end

    // pci enable reloads from the mode at cold reset end; software may
    // change it afterwards, but a cold release in the same cycle wins
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pci_enable <= `BSVC_PCI_EN_RESET;
        end
        else if (cold_release)
        begin
            pci_enable <=
                pci_en_for_mode(shadow[`BSVC_F_PCI_HI:`BSVC_F_PCI_LO]);
        end
        else if (!cold_reset_n)
        begin
            pci_enable <= `BSVC_PCI_EN_RESET;
        end
        else if (reg_write && addr_hit(reg_addr, `BSVC_OFF_PCI_CTRL))
        begin
            pci_enable <= reg_wdata[0];
        end
    end

    // software warm reset request; a one-cycle strobe, ignored in cold reset
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            soft_warm <= 1'b0;
            ext_guard <= 1'b0;
            warm_reset_exception <= 1'b0;
        end
        else
        begin
            soft_warm <= config_valid && reg_write && reg_wdata[0]
                && addr_hit(reg_addr, `BSVC_OFF_WARM_CTRL);
            ext_guard <= drive_busy;
            warm_reset_exception <= ext_warm;
        end
    end

    bsvc_decode u_decode
    (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .load(capture),
        .vector(vector),
        .cpu_clk_mult(cpu_clk_mult),
        .big_endian(big_endian),
        .boot_width(boot_width),
        .reset_mode(reset_mode),
        .watchdog_enable(watchdog_enable),
        .pci_mode(pci_mode),
        .reserved_code(reserved_code)
    );

    // reset mode 1 is reserved; the line is stretched anyway so that a
    // bad strap still yields a usable warm reset rather than none
    bsvc_warm_drive
    #(
        .CYCLES(WARM_DRIVE_CYCLES)
    )
    u_warm
    (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .start(warm_start),
        .line_out(warm_reset_line_n_out),
        .line_oe(warm_reset_line_n_oe),
        .busy(drive_busy)
    );

    always @*
    begin
        next_rdata = 32'h0000_0000;
        if (addr_hit(reg_addr, `BSVC_OFF_VECTOR))
        begin
            next_rdata[`BSVC_VEC_W-1:0] = vector;
        end
        else if (addr_hit(reg_addr, `BSVC_OFF_PCI_CTRL))
        begin
            next_rdata[0] = pci_enable;
            next_rdata[3:1] = pci_mode;
        end
        else if (addr_hit(reg_addr, `BSVC_OFF_CONFIG))
        begin
            next_rdata[2:0] = cpu_clk_mult;
            next_rdata[3] = big_endian;
            next_rdata[5:4] = boot_width;
            next_rdata[6] = reset_mode;
            next_rdata[7] = watchdog_enable;
            next_rdata[8] = reserved_code;
            next_rdata[9] = config_valid;
        end
        else if (addr_hit(reg_addr, `BSVC_OFF_WARM_CTRL))
        begin
            next_rdata[1] = drive_busy;
        end
    end

    // read data stand only in the cycle after the strobe
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reg_rdata <= 32'h0000_0000;
        end
        else if (reg_read)
        begin
            reg_rdata <= next_rdata;
        end
        else
        begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule // bsvc_top

// [verif/bsvc_chk_assertions.sv]
// assertions on the boot strap vector capture ports
`timescale 1ns/1ps
`include "bsvc_regs.vh"
module bsvc_chk
#(
    parameter WARM_DRIVE_CYCLES = `BSVC_WARM_DRIVE_CYCLES
)
(
    input wire core_clk,
    input wire reset_n,
    input wire cold_reset_n,
    input wire [`BSVC_VEC_W-1:0] memory_data_bus,
    input wire warm_reset_line_n_in,
    input wire warm_reset_line_n_out,
    input wire warm_reset_line_n_oe,
    input wire [2:0] cpu_clk_mult,
    input wire big_endian,
    input wire [1:0] boot_width,
    input wire watchdog_enable,
    input wire [2:0] pci_mode,
    input wire pci_enable,
    input wire config_valid,
    input wire pll_relock,
    input wire cold_reset_active,
    input wire warm_reset_exception
);
    reg [15:0] low_vec;
    reg [15:0] oe_cnt;
    wire [9:0] cfg;
    wire [9:0] exp_cfg;
    assign cfg = {cpu_clk_mult, big_endian, boot_width, watchdog_enable,
        pci_mode};
    assign exp_cfg = {low_vec[2:0], low_vec[3], low_vec[6:5], ~low_vec[8],
        low_vec[11:9]};
    // shadow of the last vector seen while cold reset was low
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            low_vec <= 16'h0000;
            oe_cnt <= 16'h0000;
        end
        else
        begin
            if (!cold_reset_n)
                low_vec <= memory_data_bus;
            oe_cnt <= warm_reset_line_n_oe ? oe_cnt + 16'h0001 : 16'h0000;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    property p_load_edge;
        $rose(config_valid) |-> $past(cold_reset_n) && !$past(cold_reset_n, 2);
    endproperty
    a_load_edge: assert property (p_load_edge)
        else $error("settings loaded outside cold release");
    property p_cold_clear;
        !cold_reset_n |=> !config_valid;
    endproperty
    a_cold_clear: assert property (p_cold_clear)
        else $error("config_valid high in cold reset");
    property p_relock;
        !cold_reset_n |=> pll_relock && cold_reset_active;
    endproperty
    a_relock: assert property (p_relock)
        else $error("relock missing in cold reset");
    // three cycles of margin cover the decode pipeline after release
    property p_hold;
        config_valid && $past(config_valid, 3) |-> $stable(cfg);
    endproperty
    a_hold: assert property (p_hold)
        else $error("settings moved after cold release");
    property p_decode;
        config_valid && $past(config_valid, 3) |-> cfg == exp_cfg;
    endproperty
    a_decode: assert property (p_decode)
        else $error("settings differ from captured vector");
    property p_pci_en;
        $rose(config_valid) |->
            pci_enable == (low_vec[11:9] == 3'h1 || low_vec[11:9] == 3'h2);
    endproperty
    a_pci_en: assert property (p_pci_en)
        else $error("pci enable initial value wrong");
    property p_drive_start;
        $rose(config_valid) |->
            ##2 (warm_reset_line_n_oe && !warm_reset_line_n_out);
    endproperty
    a_drive_start: assert property (p_drive_start)
        else $error("warm line not driven after cold release");
    property p_drive_len;
        $fell(warm_reset_line_n_oe) |-> oe_cnt == WARM_DRIVE_CYCLES;
    endproperty
    a_drive_len: assert property (p_drive_len)
        else $error("warm line drive length wrong");
    property p_ext_warm;
        warm_reset_exception |-> warm_reset_line_n_oe &&
            !$past(warm_reset_line_n_in) ##1 !warm_reset_exception;
    endproperty
    a_ext_warm: assert property (p_ext_warm)
        else $error("outside warm reset handled wrongly");
endmodule // bsvc_chk

// [verif/bsvc_board.sv]
// board strapping and warm reset wire seen from outside the device
`timescale 1ns/1ps
module bsvc_board
(
    input wire core_clk,
    input wire cold_reset_n,
    input wire [15:0] vector,
    input wire force_warm,
    input wire warm_reset_line_n_out,
    input wire warm_reset_line_n_oe,
    output wire [15:0] memory_data_bus,
    output wire warm_reset_line_n
);
    reg [15:0] churn = 16'h0000;
    always @(posedge core_clk)
        churn <= churn + 16'h3b5d;
    // after cold reset the bus carries other traffic, so a late load shows
    assign memory_data_bus = cold_reset_n ? ~vector ^ churn : vector;
    // wired low with a board pull-up
    assign warm_reset_line_n = ~((warm_reset_line_n_oe
        & ~warm_reset_line_n_out) | force_warm);
endmodule // bsvc_board

// [verif/boot_strap_vector_capture_tb.sv]
// testbench for the boot strap vector capture block
`timescale 1ns/1ps
`include "bsvc_regs.vh"
module boot_strap_vector_capture_tb;
    localparam WARM = 16;
    reg core_clk = 1'b0;
    reg reset_n = 1'b0;
    reg cold_reset_n = 1'b0;
    reg [15:0] vector = 16'h0000;
    reg force_warm = 1'b0;
    reg [7:0] reg_addr = 8'h00;
    reg [31:0] reg_wdata = 32'h0;
    reg reg_write = 1'b0;
    reg reg_read = 1'b0;
    wire [15:0] mdb;
    wire w_line, w_out, w_oe, pci_en, cv, relock, cra, exc, big_e, wd_en;
    wire [31:0] rdata;
    wire [2:0] mult, pmode;
    wire [1:0] width;
    integer n_errors = 0;
    integer n_tests = 0;
    integer i;
    reg [31:0] d;
    reg [15:0] v;
    reg [2:0] m;
    reg [1:0] w;
    always #2 core_clk = ~core_clk;
    bsvc_top #(.WARM_DRIVE_CYCLES(WARM)) dut (.core_clk(core_clk),
        .reset_n(reset_n), .cold_reset_n(cold_reset_n),
        .memory_data_bus(mdb), .warm_reset_line_n_in(w_line),
        .warm_reset_line_n_out(w_out), .warm_reset_line_n_oe(w_oe),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(rdata), .cpu_clk_mult(mult),
        .big_endian(big_e), .boot_width(width), .watchdog_enable(wd_en),
        .pci_mode(pmode), .pci_enable(pci_en), .config_valid(cv),
        .pll_relock(relock), .cold_reset_active(cra),
        .warm_reset_exception(exc));
    bsvc_board board (.core_clk(core_clk), .cold_reset_n(cold_reset_n),
        .vector(vector), .force_warm(force_warm),
        .warm_reset_line_n_out(w_out), .warm_reset_line_n_oe(w_oe),
        .memory_data_bus(mdb), .warm_reset_line_n(w_line));
    task chk(input [8*10-1:0] what, input [31:0] e, input [31:0] g);
    begin
        n_tests = n_tests + 1;
        if (e !== g)
        begin
            n_errors = n_errors + 1;
            $display("unexpected %0s exp %h got %h", what, e, g);
        end
    end
    endtask
    task rd(input [7:0] a, output [31:0] q);
    begin
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 q = rdata;
    end
    endtask
    task wr(input [7:0] a, input [31:0] q);
    begin
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= q;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    end
    endtask
    task wrap_up;
    begin
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    initial
    begin
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        for (i = 0; i < 6; i = i + 1)
        begin
            m = i[2:0];
            d = i % 3;
            w = d[1:0];
            // reserved codes are never strapped
            v = {i[3:0] ^ 4'h9, m, i[1], 1'b0, w, i[0], ~i[0], 3'h0};
            @(posedge core_clk);
            cold_reset_n <= 1'b0;
            vector <= v;
            repeat (2) @(posedge core_clk);
            #1 chk("in cold", 32'h3, {29'h0, cv, relock, cra});
            @(posedge core_clk);
            cold_reset_n <= 1'b1;
            repeat (4) @(posedge core_clk);
            #1 chk("settings", {3'h0, v[3], v[6:5], ~v[8], v[11:9],
                m == 3'h1 || m == 3'h2}, {mult, big_e, width, wd_en, pmode,
                pci_en});
            chk("status", 32'h4, {29'h0, cv, relock, cra});
            chk("line", 0, w_line);
            rd(8'h00, d);
            chk("vector", v, d);
            repeat (WARM) @(posedge core_clk);
            #1 chk("line idle", 1, w_line);
            $display("test boot %0d done", i);
        end
        @(posedge core_clk);
        force_warm <= 1'b1;
        @(posedge core_clk);
        #1 chk("exception", 1, exc);
        @(posedge core_clk);
        force_warm <= 1'b0;
        #1 chk("exception", 0, exc);
        chk("line oe", 1, w_oe);
        repeat (WARM + 4) @(posedge core_clk);
        $display("test outside warm reset done");
        wr(8'h04, 32'h1);
        rd(8'h04, d);
        chk("pci ctrl", 32'hb, d);
        wr(8'h00, 32'hffff);
        rd(8'h00, d);
        chk("vector ro", v, d);
        rd(8'h08, d);
        chk("config", {22'h0, 2'h2, ~v[8], v[7:5], v[3:0]}, d);
        rd(8'h10, d);
        chk("unmapped", 0, d);
        wr(8'h0c, 32'h1);
        repeat (2) @(posedge core_clk);
        #1 chk("soft warm", 1, w_oe);
        rd(8'h0c, d);
        chk("warm busy", 32'h2, d);
        repeat (WARM + 4) @(posedge core_clk);
        $display("test registers done");
        wrap_up;
    end
    // whole run is a few hundred cycles
    initial
    begin
        #8000;
        n_errors = n_errors + 1;
        wrap_up;
    end
endmodule // boot_strap_vector_capture_tb
bind bsvc_top bsvc_chk #(.WARM_DRIVE_CYCLES(WARM_DRIVE_CYCLES)) u_chk (
    .core_clk(core_clk), .reset_n(reset_n), .cold_reset_n(cold_reset_n),
    .memory_data_bus(memory_data_bus),
    .warm_reset_line_n_in(warm_reset_line_n_in),
    .warm_reset_line_n_out(warm_reset_line_n_out),
    .warm_reset_line_n_oe(warm_reset_line_n_oe),
    .cpu_clk_mult(cpu_clk_mult), .big_endian(big_endian),
    .boot_width(boot_width), .watchdog_enable(watchdog_enable),
    .pci_mode(pci_mode), .pci_enable(pci_enable),
    .config_valid(config_valid), .pll_relock(pll_relock),
    .cold_reset_active(cold_reset_active),
    .warm_reset_exception(warm_reset_exception));
